/* File: rtl/raf_defines.svh */
// raf_defines.svh: offsets, field positions and timing counts of the filter
// assumes: included by bare name from the region match, filter and master files
`ifndef RAF_DEFINES_SVH
`define RAF_DEFINES_SVH
`define RAF_NREG        9
`define RAF_NSUB        8
`define RAF_SID_W       4
`define RAF_NSID        16
`define RAF_PAGE_LSB    12
`define RAF_PROT_NS_BIT 1
`define RAF_FAST_LAT    2'h1
`define RAF_NORM_LAT    2'h2
`define RAF_WR_LAT      2'h2
`define RAF_FAST_MAX    32
`define RAF_RESP_DENY   2'h0
`define RAF_DEF_SID     4'h0
`define RAF_VNET_W      2
`endif

/* File: rtl/raf_pkg.sv */
// raf_pkg: shared types of the region access filter
// assumes: compiled before the interface and all modules
package raf_pkg;
    typedef enum logic [1:0] {STG_IDLE, STG_DELAY, STG_SEND} raf_stg_e;
    typedef enum logic [1:0] {MS_IDLE, MS_ADDR, MS_WAIT} raf_mst_e;
    typedef logic [3:0] raf_sid_t;
    typedef logic [3:0] raf_rsel_t;
endpackage

/* File: rtl/raf_if.sv */
// raf_if: link between a requesting master end and one filter unit
// assumes: both ends share i_clk_sys; single-beat reads and writes
`timescale 1ns/1ps
`default_nettype none
interface raf_if #(
    parameter int ADDR_W = 32,
    parameter int DATA_W = 32
) ();
    logic                    ar_valid;
    logic                    ar_ready;
    logic [ADDR_W-1:0]       ar_addr;
    logic [2:0]              ar_prot;
    raf_pkg::raf_sid_t       ar_sid;
    logic                    ar_fast;
    logic                    aw_valid;
    logic                    aw_ready;
    logic [ADDR_W-1:0]       aw_addr;
    logic [2:0]              aw_prot;
    raf_pkg::raf_sid_t       aw_sid;
    logic [DATA_W-1:0]       w_data;
    logic [DATA_W/8-1:0]     w_strb;
    logic                    r_valid;
    logic                    r_ready;
    logic [DATA_W-1:0]       r_data;
    logic [1:0]              r_resp;
    logic                    b_valid;
    logic                    b_ready;
    logic [1:0]              b_resp;
    logic                    vn_enable;
    logic                    fast_full;

    modport filt (
        input  ar_valid, ar_addr, ar_prot, ar_sid, ar_fast,
        input  aw_valid, aw_addr, aw_prot, aw_sid, w_data, w_strb,
        input  r_ready, b_ready, vn_enable,
        output ar_ready, aw_ready, r_valid, r_data, r_resp,
        output b_valid, b_resp, fast_full
    );
    modport mst (
        output ar_valid, ar_addr, ar_prot, ar_sid, ar_fast,
        output aw_valid, aw_addr, aw_prot, aw_sid, w_data, w_strb,
        output r_ready, b_ready, vn_enable,
        input  ar_ready, aw_ready, r_valid, r_data, r_resp,
        input  b_valid, b_resp, fast_full
    );
endinterface
`default_nettype wire

/* File: rtl/raf_region_match.sv */
// raf_region_match: finds the enabled region 1..8 holding an address
// assumes: base/top are 4KB page numbers, region k in slice k-1
`timescale 1ns/1ps
`default_nettype none
`include "raf_defines.svh"
module raf_region_match #(
    parameter int ADDR_W = 32
) (
    input  wire logic [ADDR_W-1:0]                      i_addr,
    input  wire logic [`RAF_NSUB-1:0]                   i_en,
    input  wire logic [`RAF_NSUB*(ADDR_W-`RAF_PAGE_LSB)-1:0] i_base,
    input  wire logic [`RAF_NSUB*(ADDR_W-`RAF_PAGE_LSB)-1:0] i_top,
    output logic      [3:0]                             o_sel,
    output logic                                        o_overlap
);
    localparam int PGW = ADDR_W - `RAF_PAGE_LSB;
    logic [PGW-1:0]       page;
    logic [`RAF_NSUB-1:0] hit;

    assign page = i_addr[ADDR_W-1:`RAF_PAGE_LSB];

    for (genvar k = 0; k < `RAF_NSUB; k++) begin : g_reg
        assign hit[k] = i_en[k]
                      & (page >= i_base[k*PGW +: PGW])
                      & (page <= i_top[k*PGW +: PGW]);
    end

    // region 0 is the fallback and is never a hit, so it cannot overlap
    always_comb begin
        o_sel = 4'h0;
        for (int k = `RAF_NSUB - 1; k >= 0; k--) begin
            if (hit[k]) begin
                o_sel = 4'(k + 1);
            end
        end
    end

    assign o_overlap = |(hit & (hit - 8'h01));
endmodule
`default_nettype wire

/* File: rtl/raf_filter.sv */
// raf_filter: one filter unit between the link and the protected slave
// assumes: slave answers in issue order; config inputs are quasi-static
`timescale 1ns/1ps
`default_nettype none
`include "raf_defines.svh"
module raf_filter #(
    parameter int ADDR_W     = 32,
    parameter int DATA_W     = 32,
    parameter int FAST_DEPTH = 8,
    parameter int NORM_DEPTH = 64,
    parameter int ADDR_SLICE = 0,
    parameter logic [`RAF_VNET_W-1:0] NORM_VNET = 2'h0
) (
    input  wire logic                        i_clk_sys,
    input  wire logic                        i_nrst,
    raf_if.filt                              lnk,
    input  wire logic [`RAF_NSUB-1:0]        i_region_en,
    input  wire logic [`RAF_NSUB*(ADDR_W-`RAF_PAGE_LSB)-1:0] i_region_base,
    input  wire logic [`RAF_NSUB*(ADDR_W-`RAF_PAGE_LSB)-1:0] i_region_top,
    input  wire logic [`RAF_NREG-1:0]        i_sec_rd_en,
    input  wire logic [`RAF_NREG-1:0]        i_sec_wr_en,
    input  wire logic [`RAF_NREG*`RAF_NSID-1:0] i_region_source_permit_rd,
    input  wire logic [`RAF_NREG*`RAF_NSID-1:0] i_region_source_permit_wr,
    input  wire logic                        i_spec_rd_off,
    input  wire logic                        i_spec_wr_off,
    input  wire logic [`RAF_VNET_W-1:0]      i_fast_path_network_select,
    input  wire logic                        i_overlap_clear,
    output logic                             o_overlap_status,
    output logic                             o_ds_ar_valid,
    input  wire logic                        i_ds_ar_ready,
    output logic      [ADDR_W-1:0]           o_ds_ar_addr,
    output logic      [2:0]                  o_ds_ar_prot,
    output logic      [`RAF_VNET_W-1:0]      o_ds_ar_vnet,
    input  wire logic                        i_ds_r_valid,
    output logic                             o_ds_r_ready,
    input  wire logic [DATA_W-1:0]           i_ds_r_data,
    input  wire logic [1:0]                  i_ds_r_resp,
    output logic                             o_ds_aw_valid,
    input  wire logic                        i_ds_aw_ready,
    output logic      [ADDR_W-1:0]           o_ds_aw_addr,
    output logic      [2:0]                  o_ds_aw_prot,
    output logic      [DATA_W-1:0]           o_ds_w_data,
    output logic      [DATA_W/8-1:0]         o_ds_w_strb,
    input  wire logic                        i_ds_b_valid,
    output logic                             o_ds_b_ready,
    input  wire logic [1:0]                  i_ds_b_resp
);
    localparam int PW = $clog2(NORM_DEPTH);
    localparam int FW = $clog2(FAST_DEPTH + 1);

    if (FAST_DEPTH < 1 || FAST_DEPTH > `RAF_FAST_MAX
        || NORM_DEPTH <= FAST_DEPTH || (1 << PW) != NORM_DEPTH
        || ADDR_SLICE < 0 || ADDR_SLICE > 1) begin : g_bad_cfg
        $error("raf_filter: unsupported depth or slice parameters");
    end

    typedef struct packed {
        raf_pkg::raf_stg_e        rs;
        logic [1:0]               rcnt;
        logic [ADDR_W-1:0]        raddr;
        logic [2:0]               rprot;
        logic [`RAF_VNET_W-1:0]   rvnet;
        logic                     rfail;
        logic                     rspec;
        logic                     rfast;
        logic [NORM_DEPTH-1:0]    rfq;
        logic [NORM_DEPTH-1:0]    rffq;
        logic [PW-1:0]            rhead;
        logic [PW-1:0]            rtail;
        logic [PW:0]              rout;
        logic [FW-1:0]            rfo;
        logic                     rv;
        logic [DATA_W-1:0]        rdata;
        logic [1:0]               rresp;
        raf_pkg::raf_stg_e        ws;
        logic [1:0]               wcnt;
        logic [ADDR_W-1:0]        waddr;
        logic [2:0]               wprot;
        logic [DATA_W-1:0]        wdata;
        logic [DATA_W/8-1:0]      wstrb;
        logic                     wfail;
        logic                     wspec;
        logic [PW:0]              wout;
        logic                     bv;
        logic [1:0]               bresp;
        logic                     ovl;
    } raf_filt_s;

    raf_filt_s s_r;
    raf_filt_s s_nxt;

    raf_pkg::raf_rsel_t rsel;
    raf_pkg::raf_rsel_t wsel;
    logic               rovl;
    logic               wovl;
    logic               r_ok;
    logic               w_ok;
    logic               r_spec;
    logic               w_spec;
    logic               r_fast;
    logic               fast_full;
    logic               r_fwd;
    logic               w_fwd;
    logic               r_push;
    logic               r_pop;
    logic               w_push;
    logic               w_pop;
    logic               ar_take;
    logic               aw_take;

    // region 0 is implicit: a miss on 1..8 selects it
    raf_region_match #(.ADDR_W(ADDR_W)) u_rd_match (
        .i_addr    (lnk.ar_addr),
        .i_en      (i_region_en),
        .i_base    (i_region_base),
        .i_top     (i_region_top),
        .o_sel     (rsel),
        .o_overlap (rovl)
    );
    raf_region_match #(.ADDR_W(ADDR_W)) u_wr_match (
        .i_addr    (lnk.aw_addr),
        .i_en      (i_region_en),
        .i_base    (i_region_base),
        .i_top     (i_region_top),
        .o_sel     (wsel),
        .o_overlap (wovl)
    );

    // secure uses only its own enable; nonsecure the identity bit
    assign r_ok = !lnk.ar_prot[`RAF_PROT_NS_BIT]
                ? i_sec_rd_en[rsel]
                : i_region_source_permit_rd[{rsel, lnk.ar_sid}];
    assign w_ok = !lnk.aw_prot[`RAF_PROT_NS_BIT]
                ? i_sec_wr_en[wsel]
                : i_region_source_permit_wr[{wsel, lnk.aw_sid}];

    assign r_spec    = lnk.vn_enable | ~i_spec_rd_off;
    assign w_spec    = lnk.vn_enable | ~i_spec_wr_off;
    assign fast_full = s_r.rfo >= FW'(FAST_DEPTH);
    // a full fast path falls back to the normal path instead of stalling
    assign r_fast    = lnk.ar_fast & r_spec & ~fast_full;
    assign r_fwd     = ~s_r.rfail | s_r.rspec;
    assign w_fwd     = ~s_r.wfail | s_r.wspec;

    assign ar_take = lnk.ar_valid & lnk.ar_ready;
    assign aw_take = lnk.aw_valid & lnk.aw_ready;
    assign r_push  = o_ds_ar_valid & i_ds_ar_ready;
    assign w_push  = o_ds_aw_valid & i_ds_aw_ready;
    assign r_pop   = i_ds_r_valid & o_ds_r_ready;
    assign w_pop   = i_ds_b_valid & o_ds_b_ready;

    assign lnk.ar_ready  = s_r.rs == raf_pkg::STG_IDLE;
    assign lnk.aw_ready  = s_r.ws == raf_pkg::STG_IDLE;
    assign lnk.r_valid   = s_r.rv;
    assign lnk.r_data    = s_r.rdata;
    assign lnk.r_resp    = s_r.rresp;
    assign lnk.b_valid   = s_r.bv;
    assign lnk.b_resp    = s_r.bresp;
    assign lnk.fast_full = fast_full;

    assign o_ds_ar_valid = (s_r.rs == raf_pkg::STG_SEND) & r_fwd
                         & (s_r.rout < (PW+1)'(NORM_DEPTH));
    assign o_ds_ar_addr  = s_r.raddr;
    assign o_ds_ar_prot  = s_r.rprot;
    assign o_ds_ar_vnet  = s_r.rvnet;
    assign o_ds_r_ready  = ~s_r.rv & (s_r.rout != '0);
    assign o_ds_aw_valid = (s_r.ws == raf_pkg::STG_SEND) & w_fwd
                         & (s_r.wout < (PW+1)'(NORM_DEPTH));
    assign o_ds_aw_addr  = s_r.waddr;
    assign o_ds_aw_prot  = s_r.wprot;
    assign o_ds_w_data   = s_r.wdata;
    assign o_ds_w_strb   = s_r.wstrb;
    assign o_ds_b_ready  = ~s_r.bv & (s_r.wout != '0);
    assign o_overlap_status = s_r.ovl;

    always_comb begin
        s_nxt = s_r;
        if (s_r.rv & lnk.r_ready) begin
            s_nxt.rv = 1'b0;
        end
        if (s_r.bv & lnk.b_ready) begin
            s_nxt.bv = 1'b0;
        end
        case (s_r.rs)
            raf_pkg::STG_IDLE: begin
                if (lnk.ar_valid) begin
                    s_nxt.rs    = raf_pkg::STG_DELAY;
                    // normal path costs one cycle more
                    s_nxt.rcnt  = (r_fast ? `RAF_FAST_LAT : `RAF_NORM_LAT)
                                + 2'(ADDR_SLICE) - 2'h1;
                    s_nxt.raddr = lnk.ar_addr;
                    s_nxt.rprot = lnk.ar_prot;
                    s_nxt.rfail = ~r_ok;
                    s_nxt.rspec = r_spec;
                    s_nxt.rfast = r_fast;
                    s_nxt.rvnet = (r_fast & lnk.vn_enable)
                                ? i_fast_path_network_select : NORM_VNET;
                end
            end
            raf_pkg::STG_DELAY: begin
                if (s_r.rcnt == 2'h0) begin
                    s_nxt.rs = raf_pkg::STG_SEND;
                end else begin
                    s_nxt.rcnt = s_r.rcnt - 2'h1;
                end
            end
            raf_pkg::STG_SEND: begin
                if (r_push) begin
                    s_nxt.rs = raf_pkg::STG_IDLE;
                end else if (~r_fwd & (s_r.rout == '0) & ~s_r.rv) begin
                    // wait for older reads so answers keep their order
                    s_nxt.rs    = raf_pkg::STG_IDLE;
                    s_nxt.rv    = 1'b1;
                    s_nxt.rdata = '0;
                    s_nxt.rresp = `RAF_RESP_DENY;
                end
            end
            default: s_nxt.rs = raf_pkg::STG_IDLE;
        endcase
        case (s_r.ws)
            raf_pkg::STG_IDLE: begin
                if (lnk.aw_valid) begin
                    s_nxt.ws    = raf_pkg::STG_DELAY;
                    s_nxt.wcnt  = `RAF_WR_LAT + 2'(ADDR_SLICE) - 2'h1;
                    s_nxt.waddr = lnk.aw_addr;
                    s_nxt.wprot = lnk.aw_prot;
                    s_nxt.wdata = w_ok ? lnk.w_data : '0;
                    s_nxt.wstrb = w_ok ? lnk.w_strb : '0;
                    s_nxt.wfail = ~w_ok;
                    s_nxt.wspec = w_spec;
                end
            end
            raf_pkg::STG_DELAY: begin
                if (s_r.wcnt == 2'h0) begin
                    s_nxt.ws = raf_pkg::STG_SEND;
                end else begin
                    s_nxt.wcnt = s_r.wcnt - 2'h1;
                end
            end
            raf_pkg::STG_SEND: begin
                if (w_push) begin
                    s_nxt.ws = raf_pkg::STG_IDLE;
                end else if (~w_fwd & (s_r.wout == '0) & ~s_r.bv) begin
                    s_nxt.ws    = raf_pkg::STG_IDLE;
                    s_nxt.bv    = 1'b1;
                    s_nxt.bresp = `RAF_RESP_DENY;
                end
            end
            default: s_nxt.ws = raf_pkg::STG_IDLE;
        endcase
        if (r_push) begin
            s_nxt.rfq[s_r.rtail]  = s_r.rfail;
            s_nxt.rffq[s_r.rtail] = s_r.rfast;
            s_nxt.rtail = s_r.rtail + 1'b1;
        end
        if (r_pop) begin
            s_nxt.rv    = 1'b1;
            s_nxt.rdata = s_r.rfq[s_r.rhead] ? '0 : i_ds_r_data;
            s_nxt.rresp = i_ds_r_resp;
            s_nxt.rhead = s_r.rhead + 1'b1;
        end
        if (w_pop) begin
            s_nxt.bv    = 1'b1;
            s_nxt.bresp = i_ds_b_resp;
        end
        s_nxt.rout = s_r.rout + (PW+1)'(r_push) - (PW+1)'(r_pop);
        s_nxt.wout = s_r.wout + (PW+1)'(w_push) - (PW+1)'(w_pop);
        s_nxt.rfo  = s_r.rfo + FW'(r_push & s_r.rfast)
                   - FW'(r_pop & s_r.rffq[s_r.rhead]);
        // a new overlap in the clearing cycle wins over the clear
        s_nxt.ovl  = (ar_take & rovl) | (aw_take & wovl)
                   | (s_r.ovl & ~i_overlap_clear);
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule
`default_nettype wire

/* File: rtl/raf_master.sv */
// raf_master: requesting end of the link, one transfer at a time
// assumes: user command held stable while o_cmd_ready is low is not needed
`timescale 1ns/1ps
`default_nettype none
`include "raf_defines.svh"
module raf_master #(
    parameter int ADDR_W         = 32,
    parameter int DATA_W         = 32,
    parameter bit HAS_ID         = 1'b1,
    parameter bit LAT_INTOLERANT = 1'b0
) (
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_nrst,
    raf_if.mst                         lnk,
    input  wire logic                  i_cmd_valid,
    output logic                       o_cmd_ready,
    input  wire logic                  i_cmd_write,
    input  wire logic [ADDR_W-1:0]     i_cmd_addr,
    input  wire logic                  i_cmd_secure,
    input  wire logic [`RAF_SID_W-1:0] i_cmd_sid,
    input  wire logic                  i_cmd_fast,
    input  wire logic [DATA_W-1:0]     i_cmd_wdata,
    input  wire logic [DATA_W/8-1:0]   i_cmd_wstrb,
    input  wire logic                  i_vn_participate,
    output logic                       o_done,
    output logic      [DATA_W-1:0]     o_rdata,
    output logic      [1:0]            o_resp
);
    typedef struct packed {
        raf_pkg::raf_mst_e    st;
        logic                 wr;
        logic [ADDR_W-1:0]    addr;
        logic [2:0]           prot;
        raf_pkg::raf_sid_t    sid;
        logic                 fast;
        logic [DATA_W-1:0]    wdata;
        logic [DATA_W/8-1:0]  wstrb;
        logic                 done;
        logic [DATA_W-1:0]    rdata;
        logic [1:0]           resp;
    } raf_mst_s;

    raf_mst_s s_r;
    raf_mst_s s_nxt;
    logic     ar_go;

    // hold fast reads back while the filter's fast path is full
    assign ar_go = ~(s_r.fast & lnk.fast_full);

    assign o_cmd_ready   = s_r.st == raf_pkg::MS_IDLE;
    assign o_done        = s_r.done;
    assign o_rdata       = s_r.rdata;
    assign o_resp        = s_r.resp;
    assign lnk.ar_valid  = (s_r.st == raf_pkg::MS_ADDR) & ~s_r.wr & ar_go;
    assign lnk.aw_valid  = (s_r.st == raf_pkg::MS_ADDR) & s_r.wr;
    assign lnk.ar_addr   = s_r.addr;
    assign lnk.aw_addr   = s_r.addr;
    assign lnk.ar_prot   = s_r.prot;
    assign lnk.aw_prot   = s_r.prot;
    assign lnk.ar_sid    = s_r.sid;
    assign lnk.aw_sid    = s_r.sid;
    assign lnk.ar_fast   = s_r.fast;
    assign lnk.w_data    = s_r.wdata;
    assign lnk.w_strb    = s_r.wstrb;
    assign lnk.r_ready   = (s_r.st == raf_pkg::MS_WAIT) & ~s_r.wr;
    assign lnk.b_ready   = (s_r.st == raf_pkg::MS_WAIT) & s_r.wr;
    assign lnk.vn_enable = i_vn_participate;

    always_comb begin
        s_nxt      = s_r;
        s_nxt.done = 1'b0;
        case (s_r.st)
            raf_pkg::MS_IDLE: begin
                if (i_cmd_valid) begin
                    s_nxt.st    = raf_pkg::MS_ADDR;
                    s_nxt.wr    = i_cmd_write;
                    s_nxt.addr  = i_cmd_addr;
                    s_nxt.prot  = {1'b0, ~i_cmd_secure, 1'b0};
                    s_nxt.sid   = HAS_ID ? i_cmd_sid : `RAF_DEF_SID;
                    s_nxt.fast  = LAT_INTOLERANT | i_cmd_fast;
                    s_nxt.wdata = i_cmd_wdata;
                    s_nxt.wstrb = i_cmd_wstrb;
                end
            end
            raf_pkg::MS_ADDR: begin
                if ((lnk.aw_valid & lnk.aw_ready)
                    | (lnk.ar_valid & lnk.ar_ready)) begin
                    s_nxt.st = raf_pkg::MS_WAIT;
                end
            end
            raf_pkg::MS_WAIT: begin
                if (lnk.b_ready & lnk.b_valid) begin
                    s_nxt.st   = raf_pkg::MS_IDLE;
                    s_nxt.done = 1'b1;
                    s_nxt.resp = lnk.b_resp;
                end else if (lnk.r_ready & lnk.r_valid) begin
                    s_nxt.st    = raf_pkg::MS_IDLE;
                    s_nxt.done  = 1'b1;
                    s_nxt.resp  = lnk.r_resp;
                    s_nxt.rdata = lnk.r_data;
                end
            end
            default: s_nxt.st = raf_pkg::MS_IDLE;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule
`default_nettype wire

/* File: tb/raf_link_sva.sv */
// raf_link_sva: timing checks on the link between master end and filter
// assumes: inputs carry the link signals, one clock, low-active reset
`timescale 1ns/1ps
`default_nettype none
module raf_link_sva #(parameter int ADDR_W = 32, parameter int DATA_W = 32) (
    input wire logic              i_clk_sys, i_nrst, ar_valid, ar_ready,
    input wire logic [ADDR_W-1:0] ar_addr,
    input wire logic              ar_fast, aw_valid, aw_ready, r_valid,
    input wire logic [DATA_W-1:0] r_data,
    input wire logic              r_ready, b_valid, b_ready, fast_full
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    a_rd_hold: assert property (
        r_valid && !r_ready |=> r_valid && $stable(r_data)) else $error("r drop");
    a_wr_hold: assert property (
        b_valid && !b_ready |=> b_valid) else $error("b dropped");
    a_rd_answer: assert property (
        ar_valid && ar_ready |-> ##[1:40] r_valid) else $error("no r answer");
    a_wr_answer: assert property (
        aw_valid && aw_ready |-> ##[1:40] b_valid) else $error("no b answer");
    a_rd_busy: assert property (
        ar_valid && ar_ready |=> !ar_ready) else $error("read stage reused");
    a_wr_busy: assert property (
        aw_valid && aw_ready |=> !aw_ready) else $error("write stage reused");
    a_ar_steady: assert property (
        ar_valid && !ar_ready |=> ar_valid && $stable(ar_addr)) else $error("ar");
    a_fast_hold: assert property (
        fast_full |-> !(ar_valid && ar_fast)) else $error("fast read when full");
    c_fast_rd: cover property (ar_valid && ar_ready && ar_fast);
    c_wr_take: cover property (aw_valid && aw_ready);
    c_zero_rd: cover property (r_valid && r_ready && r_data == '0);
endmodule
`default_nettype wire

/* File: tb/region_access_filter_tb.sv */
// region_access_filter_tb: master end and filter unit face each other
// assumes: bench plays the downstream slave, one transfer at a time
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
    $display("BAD %0t mismatch", $time); end end
module region_access_filter_tb;
    logic i_clk_sys = 1'h0, i_nrst = 1'h0, i_overlap_clear = 1'h0;
    logic i_spec_rd_off = 1'h0, i_spec_wr_off = 1'h0, i_vn_participate = 1'h0;
    logic i_cmd_valid = 1'h0, i_cmd_write, i_cmd_secure, i_cmd_fast;
    logic [3:0] i_cmd_sid = 4'h0, i_cmd_wstrb = 4'hF, o_ds_w_strb, ws;
    logic [31:0] i_cmd_addr = 32'h0, i_cmd_wdata, o_rdata, wd, o_ds_w_data;
    logic [31:0] i_ds_r_data = 32'h0, o_ds_ar_addr, o_ds_aw_addr;
    logic [1:0] o_resp, o_ds_ar_vnet, vnet, i_ds_r_resp = 2'h1;
    // slave answers with a nonzero code so a local deny is told apart
    logic [1:0] i_ds_b_resp = 2'h1, i_fast_path_network_select = 2'h3;
    logic [2:0] o_ds_ar_prot, o_ds_aw_prot;
    logic [34:0] ap, wp;
    logic i_ds_ar_ready = 1'h1, i_ds_aw_ready = 1'h1;
    logic i_ds_r_valid = 1'h0, i_ds_b_valid = 1'h0, o_cmd_ready, o_done;
    logic o_ds_ar_valid, o_ds_r_ready, o_ds_aw_valid, o_ds_b_ready;
    logic o_overlap_status;
    logic [7:0] i_region_en = 8'h01;
    logic [159:0] i_region_base = {8{20'h1}}, i_region_top = {8{20'h1}};
    logic [8:0] i_sec_rd_en = 9'h002, i_sec_wr_en = 9'h000;
    logic [143:0] i_region_source_permit_rd = 144'h80001;
    logic [143:0] i_region_source_permit_wr = 144'h80000;
    int err_count = 0, n_checks = 0, n_ar = 0;
    raf_if lnk ();
    raf_master raf_master_i (.*);
    raf_filter raf_filter_i (.*);
    raf_link_sva raf_link_sva_i (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
        .ar_valid(lnk.ar_valid), .ar_ready(lnk.ar_ready),
        .ar_addr(lnk.ar_addr), .ar_fast(lnk.ar_fast),
        .aw_valid(lnk.aw_valid), .aw_ready(lnk.aw_ready),
        .r_valid(lnk.r_valid), .r_data(lnk.r_data), .r_ready(lnk.r_ready),
        .b_valid(lnk.b_valid), .b_ready(lnk.b_ready),
        .fast_full(lnk.fast_full));
    always #5 i_clk_sys = ~i_clk_sys;
    // slave: read data toggles while idle so a stale bus never matches
    always @(posedge i_clk_sys) begin
        if (!i_ds_r_valid) i_ds_r_data <= ~i_ds_r_data;
        if (i_ds_r_valid && o_ds_r_ready) i_ds_r_valid <= 1'h0;
        if (i_ds_b_valid && o_ds_b_ready) i_ds_b_valid <= 1'h0;
        if (o_ds_ar_valid) begin
            {i_ds_r_valid, i_ds_r_data, vnet} <= {1'h1, 32'h5A5AC3C3, o_ds_ar_vnet};
            n_ar <= n_ar + 1;
            ap <= {o_ds_ar_prot, o_ds_ar_addr};
        end
        if (o_ds_aw_valid) begin
            {i_ds_b_valid, wd, ws} <= {1'h1, o_ds_w_data, o_ds_w_strb};
            wp <= {o_ds_aw_prot, o_ds_aw_addr};
        end
    end
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic xfer(input logic w, s, f, input logic [3:0] sid,
                        input logic [31:0] a, output int lat);
        {i_cmd_write, i_cmd_secure, i_cmd_fast, i_cmd_sid, i_cmd_addr,
         i_cmd_wdata, i_cmd_valid} <= {w, s, f, sid, a, ~a, 1'h1};
        @(posedge i_clk_sys);
        i_cmd_valid <= 1'h0;
        lat = 0;
        do begin @(negedge i_clk_sys); lat++; end
        while (o_done !== 1'h1 && lat < 60);
        `CHK(lat < 60, 1'h1)
        if (lat == 60) report_and_stop();
        `CHK(o_cmd_ready, 1'h1)
        @(posedge i_clk_sys);
    endtask
    task automatic t_secure();
        int l;
        xfer(1'h0, 1'h1, 1'h0, 4'h0, 32'h1004, l);
        `CHK(o_rdata, 32'h5A5AC3C3)
        `CHK(ap, {3'h0, 32'h1004})
        xfer(1'h1, 1'h0, 1'h0, 4'h3, 32'h1000, l);
        `CHK({wd, ws}, {~32'h1000, 4'hF})
        `CHK(wp, {3'h2, 32'h1000})
        xfer(1'h1, 1'h1, 1'h0, 4'h0, 32'h1004, l);
        `CHK({wd, ws}, 36'h0)
        xfer(1'h0, 1'h1, 1'h0, 4'h0, 32'h8000, l);
        `CHK(o_rdata, 32'h0)
    endtask
    task automatic t_nonsec();
        int l;
        xfer(1'h0, 1'h0, 1'h0, 4'h3, 32'h1000, l);
        `CHK(o_rdata, 32'h5A5AC3C3)
        xfer(1'h0, 1'h0, 1'h0, 4'h2, 32'h1000, l);
        `CHK(o_rdata, 32'h0)
        xfer(1'h0, 1'h0, 1'h0, 4'h0, 32'h8000, l);
        `CHK(o_rdata, 32'h5A5AC3C3)
    endtask
    task automatic t_nospec();
        int l, n0;
        {i_spec_rd_off, i_spec_wr_off} <= 2'h3;
        n0 = n_ar;
        xfer(1'h0, 1'h1, 1'h0, 4'h0, 32'h8000, l);
        `CHK({n_ar == n0, o_rdata, o_resp}, {1'h1, 34'h0})
        xfer(1'h1, 1'h1, 1'h0, 4'h0, 32'h1004, l);
        `CHK(o_resp, 2'h0)
        i_vn_participate <= 1'h1;
        xfer(1'h0, 1'h1, 1'h0, 4'h0, 32'h8000, l);
        `CHK(n_ar == n0 + 1, 1'h1)
        {i_spec_rd_off, i_spec_wr_off, i_vn_participate} <= 3'h0;
    endtask
    task automatic t_overlap();
        int l;
        i_region_en <= 8'h03;
        xfer(1'h0, 1'h0, 1'h0, 4'h3, 32'h1000, l);
        `CHK(o_overlap_status, 1'h1)
        {i_region_en, i_overlap_clear} <= {8'h01, 1'h1};
        @(posedge i_clk_sys);
        i_overlap_clear <= 1'h0;
        // region 1 over region 0 alone must leave the flag clear
        xfer(1'h0, 1'h0, 1'h0, 4'h3, 32'h1000, l);
        `CHK(o_overlap_status, 1'h0)
    endtask
    task automatic t_fast();
        int ln, lf;
        xfer(1'h0, 1'h0, 1'h0, 4'h3, 32'h1000, ln);
        xfer(1'h0, 1'h0, 1'h1, 4'h3, 32'h1000, lf);
        `CHK(lf < ln, 1'h1)
        i_vn_participate <= 1'h1;
        xfer(1'h0, 1'h0, 1'h1, 4'h3, 32'h1000, lf);
        `CHK(vnet, 2'h3)
        {i_vn_participate, i_spec_rd_off} <= 2'h1;
        xfer(1'h0, 1'h0, 1'h1, 4'h3, 32'h1000, lf);
        `CHK(lf, ln)
        i_spec_rd_off <= 1'h0;
    endtask
    initial begin
        repeat (10) @(posedge i_clk_sys);
        i_nrst <= 1'h1;
        @(posedge i_clk_sys);
        t_secure();
        t_nonsec();
        t_nospec();
        t_overlap();
        t_fast();
        report_and_stop();
    end
endmodule
`default_nettype wire
